/* logic/chs_port.sv */
// host select, lane steering and write strobe logic of the card port
// Operation
// - upper enable routes access to odd byte
// - lower enable picks byte by a0, upper
// - byte mux lets 8-bit hosts use low lanes
// - i/o mode decodes enables like memory
// - first chip select decodes task file
// - second chip select decodes control block
// - dma acknowledge while dma_active forces 16-bit, selects negated
// - cable select grounded makes master drive
// - pulled-up open cable select makes slave
// - memory mode ignores i/o write strobe
// - i/o write strobe latches bus data
// - capture on rising edge of strobe
// - ata without udma treats strobe as i/o
// - strobe during udma stops the burst
`timescale 1ns/1ps
`include "chs_map.svh"

// two-flop synchroniser; the first stage feeds only the second
module chs_sync2
  import chs_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_width_chk
    $error("chs_sync2 needs at least one bit");
  end

  logic [WIDTH-1:0] stage1_reg, stage1_next, stage2_reg, stage2_next;

  // plain shift; nothing may tap the first stage
  always_comb begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  // reset value is the idle level of the pins, so no edge appears at release
  always_ff @(posedge mclk) begin
    if (srst) begin
      stage1_reg <= RESET_VALUE;
      stage2_reg <= RESET_VALUE;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;
endmodule

module chs_port
  import chs_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic mclk,
  input wire logic srst,
  input wire chs_mode_t mode,
  input wire logic dma_active,
  input wire logic udma_active,
  input wire chs_pins_t pins,
  input wire logic [DATA_W-1:0] data_in,
  output chs_sel_t lane_sel,
  output logic drive_data,
  output logic is_master,
  output logic udma_stop,
  output logic write_valid,
  output chs_write_t write_word
);
  // the capture word carries one full-width data field
  if (DATA_W != $bits(chs_write_t) - $bits(chs_sel_t)) begin : g_chk
    $error("chs_port needs a data bus as wide as the capture word");
  end

  // synchronised copies; raw pins are never read directly
  chs_pins_t pins_sync;
  logic [DATA_W-1:0] data_sync;
  chs_sel_t sel_comb;
  logic strobe_prev_reg, strobe_prev_next;
  logic rise;
  logic capture_ok;
  logic master_reg, master_next;
  logic valid_reg, valid_next;
  chs_write_t word_reg, word_next;

  // pins reset to the deselected level: no false strobe edge at release
  chs_sync2 #(
    .WIDTH($bits(chs_pins_t)),
    .RESET_VALUE(`CHS_PINS_IDLE)
  ) u_pin_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in(pins),
    .sync_out(pins_sync)
  );

  // data shares the pin latency so selects and data line up at the edge
  chs_sync2 #(
    .WIDTH(DATA_W),
    .RESET_VALUE('0)
  ) u_data_sync (
    .mclk(mclk),
    .srst(srst),
    .async_in(data_in),
    .sync_out(data_sync)
  );

  // lane and register decode of the synchronised select pins
  always_comb begin
    sel_comb = CHS_NONE;
    case (mode)
      CHS_MEM, CHS_IO: begin
        // same table in memory and i/o modes
        case ({pins_sync.upper_card_enable_n, pins_sync.lower_card_enable_n})
          `CHS_CE_BOTH: begin
            sel_comb = CHS_WORD;
          end
          `CHS_CE_UPPER: begin
            sel_comb = CHS_ODD;
          end
          `CHS_CE_LOWER: begin
            // an 8-bit host reads the odd byte on the low lanes
            sel_comb = pins_sync.address_bit_zero ? CHS_ODD_LOW : CHS_EVEN;
          end
          `CHS_CE_NONE: begin
            sel_comb = CHS_NONE;
          end
          default: begin
            sel_comb = CHS_NONE;
          end
        endcase
      end
      CHS_ATA: begin
        // acknowledge counts only while a dma operation runs
        if (!pins_sync.dma_acknowledge_n && dma_active) begin
          sel_comb = CHS_WORD;
        end else if (!pins_sync.taskfile_select_n) begin
          sel_comb = CHS_TASK;
        end else if (!pins_sync.control_block_select_n) begin
          sel_comb = CHS_CTRL;
        end
      end
      default: begin
        sel_comb = CHS_NONE;
      end
    endcase
  end

  // edge detector starts at the idle level of the strobe
  always_comb begin
    strobe_prev_next = pins_sync.io_write_strobe_n;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      strobe_prev_reg <= `CHS_STROBE_IDLE;
    end else begin
      strobe_prev_reg <= strobe_prev_next;
    end
  end

  // trailing edge of the active-low strobe
  assign rise = pins_sync.io_write_strobe_n && !strobe_prev_reg;

  // strap followed only in ata mode; an open pin reads high via the pull-up
  always_comb begin
    master_next = master_reg;
    if (mode == CHS_ATA) begin
      master_next = !pins_sync.cable_select_n;
    end
  end

  // other modes keep the last strap, so a25 wiring cannot disturb it
  always_ff @(posedge mclk) begin
    if (srst) begin
      master_reg <= `CHS_MASTER_RST;
    end else begin
      master_reg <= master_next;
    end
  end

  // udma owns the strobe pin; the host negated it before entry
  assign capture_ok = mode != CHS_MEM && !(mode == CHS_ATA && udma_active);

  always_comb begin
    valid_next = 1'b0;
    word_next = word_reg;
    if (rise && capture_ok && sel_comb != CHS_NONE) begin
      valid_next = 1'b1;
      word_next.sel = sel_comb;
      word_next.data = data_sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      valid_reg <= `CHS_PULSE_RST;
      word_reg <= '0;
    end else begin
      valid_reg <= valid_next;
      word_reg <= word_next;
    end
  end

  // stop is a level; the burst logic decides when to end the transfer
  assign udma_stop = mode == CHS_ATA && udma_active && !pins_sync.io_write_strobe_n;

  // lane_sel and drive_data come straight from the decode and udma_stop from the strobe; the other outputs come from registers
  assign lane_sel = sel_comb;
  assign drive_data = sel_comb != CHS_NONE;
  assign is_master = master_reg;
  assign write_valid = valid_reg;
  assign write_word = word_reg;
endmodule

/* logic/chs_map.svh */
// constant map for the card host select strobe port
`ifndef CHS_MAP_SVH
`define CHS_MAP_SVH
`define CHS_MODE_MEM 2'h0
`define CHS_MODE_IO 2'h1
`define CHS_MODE_ATA 2'h2
`define CHS_SYNC_RST 2'h3
`define CHS_SEL_NONE 3'h0
`define CHS_SEL_EVEN 3'h1
`define CHS_SEL_ODD 3'h2
`define CHS_SEL_WORD 3'h3
`define CHS_SEL_ODD_LOW 3'h4
`define CHS_SEL_TASK 3'h5
`define CHS_SEL_CTRL 3'h6
`define CHS_CE_BOTH 2'h0
`define CHS_CE_UPPER 2'h1
`define CHS_CE_LOWER 2'h2
`define CHS_CE_NONE 2'h3
`define CHS_PINS_IDLE 8'hff
`define CHS_STROBE_IDLE 1'h1
`define CHS_MASTER_RST 1'h0
`define CHS_PULSE_RST 1'h0
`endif

/* logic/chs_pkg.sv */
// types for the card host select strobe port
package chs_pkg;
  typedef enum logic [1:0] {
    CHS_MEM = 2'b00,
    CHS_IO = 2'b01,
    CHS_ATA = 2'b10
  } chs_mode_t;
  typedef enum logic [2:0] {
    CHS_NONE = 3'b000,
    CHS_EVEN = 3'b001,
    CHS_ODD = 3'b010,
    CHS_WORD = 3'b011,
    CHS_ODD_LOW = 3'b100,
    CHS_TASK = 3'b101,
    CHS_CTRL = 3'b110
  } chs_sel_t;
  typedef struct packed {
    logic lower_card_enable_n;
    logic upper_card_enable_n;
    logic address_bit_zero;
    logic taskfile_select_n;
    logic control_block_select_n;
    logic cable_select_n;
    logic io_write_strobe_n;
    logic dma_acknowledge_n;
  } chs_pins_t;
  typedef struct packed {
    chs_sel_t sel;
    logic [15:0] data;
  } chs_write_t;
endpackage

/* test/chs_host.sv */
// host model driving the card pins
`timescale 1ns/1ps
module chs_host
  import chs_pkg::*;
(
  input wire logic mclk,
  output chs_pins_t pins,
  output logic [15:0] data
);
  initial pins = 8'hff;
  initial data = 16'h0;
  // strobe held high while selects settle; selects negated under acknowledge
  task automatic wr(input chs_pins_t p, input logic [15:0] d);
    @(negedge mclk);
    pins <= p.dma_acknowledge_n ? p | 8'h02 : p | 8'h1a;
    data <= d;
    repeat (3) @(negedge mclk);
    pins.io_write_strobe_n <= 1'b0;
    repeat (2) @(negedge mclk);
    pins.io_write_strobe_n <= 1'b1;
    repeat (2) @(negedge mclk);
    pins <= 8'hff;
    data <= ~d;
  endtask
endmodule

/* test/chs_port_checker.sv */
// assertions on the host select port
`timescale 1ns/1ps
module chs_port_checker
  import chs_pkg::*;
#(parameter int DATA_W = 16) (
  input wire logic mclk, srst, dma_active, udma_active, drive_data, is_master,
  input wire logic udma_stop, write_valid,
  input wire chs_mode_t mode,
  input wire chs_pins_t pins,
  input wire logic [DATA_W-1:0] data_in,
  input wire chs_sel_t lane_sel,
  input wire chs_write_t write_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chs_pins_t s1, s2;
  always_ff @(posedge mclk) begin
    s1 <= pins;
    s2 <= s1;
  end
  wire l = s2.lower_card_enable_n;
  wire u = s2.upper_card_enable_n;
  wire q = mode != CHS_ATA && !dma_active;
  wire t = mode == CHS_ATA && !dma_active;
  AST_NONE: assert property (q && l && u |-> lane_sel == CHS_NONE && !drive_data)
    else $error("idle");
  AST_ODD: assert property (q && l && !u |-> lane_sel == CHS_ODD)
    else $error("odd");
  AST_LOWER: assert property (q && !l && u
    |-> lane_sel == (s2.address_bit_zero ? CHS_ODD_LOW : CHS_EVEN)) else $error("lower");
  AST_DMA: assert property (mode == CHS_ATA && dma_active && !s2.dma_acknowledge_n
    |-> lane_sel == CHS_WORD) else $error("dma word");
  AST_TASK: assert property (t && !s2.taskfile_select_n |-> lane_sel == CHS_TASK)
    else $error("task");
  AST_CTRL: assert property (t && s2.taskfile_select_n && !s2.control_block_select_n
    |-> lane_sel == CHS_CTRL) else $error("ctrl");
  AST_MAST: assert property ($past(mode) == CHS_ATA
    |-> is_master == !$past(s2.cable_select_n)) else $error("strap");
  AST_STOP: assert property (udma_stop ==
    (mode == CHS_ATA && udma_active && !s2.io_write_strobe_n)) else $error("stop");
  AST_MEM: assert property (mode == CHS_MEM && $past(mode) == CHS_MEM |-> !write_valid)
    else $error("mem");
  AST_PULSE: assert property (write_valid |=> !write_valid) else $error("pulse");
  cover property (write_valid);
  cover property (udma_stop);
  cover property (is_master);
  cover property (mode == CHS_ATA && lane_sel == CHS_WORD);
endmodule
bind chs_port chs_port_checker #(.DATA_W(DATA_W)) chk (.*);

/* test/test_card_host_select_strobe_port.sv */
// bench for the host select strobe port
`timescale 1ns/1ps
module test_card_host_select_strobe_port;
  import chs_pkg::*;
  logic mclk = 0, srst = 1, udma_active = 0, dma_active = 0, write_valid, ev, mh;
  logic drive_data, is_master, udma_stop;
  logic [15:0] data_in, d;
  chs_mode_t mode = CHS_MEM;
  chs_pins_t pins, p;
  chs_sel_t lane_sel;
  chs_write_t write_word;
  int errors = 0, check_count = 0, seed = 39, n, m, es, r;
  always #5 mclk = ~mclk;
  chs_host host (.mclk, .pins, .data(data_in));
  chs_port dut (.mclk, .srst, .mode, .dma_active, .udma_active, .pins, .data_in,
    .lane_sel, .drive_data, .is_master, .udma_stop, .write_valid, .write_word);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    srst <= 0;
    for (int i = 0; i < 60; i++) begin
      @(negedge mclk);
      p = 8'($random(seed));
      d = 16'($random(seed));
      r = $random(seed);
      m = i % 3;
      mode <= chs_mode_t'(m);
      udma_active <= r[0];
      dma_active <= r[1];
      es = m == 2 ? (!p.dma_acknowledge_n ? (r[1] ? 3 : 0) : !p.taskfile_select_n ? 5 :
        !p.control_block_select_n ? 6 : 0) :
        !p.lower_card_enable_n ? (!p.upper_card_enable_n ? 3 : p.address_bit_zero ? 4 : 1) :
        !p.upper_card_enable_n ? 2 : 0;
      ev = es != 0 && (m == 1 || (m == 2 && !r[0]));
      fork
        host.wr(p, d);
        begin
          repeat (3) @(posedge mclk);
          #1 check({29'h0, lane_sel}, es);
          check({31'h0, drive_data}, {31'h0, es != 0});
          mh = is_master;
          repeat (3) @(posedge mclk);
          #1 check({31'h0, udma_stop}, {31'h0, m == 2 && r[0]});
          check({31'h0, is_master}, {31'h0, m == 2 ? !p.cable_select_n : mh});
        end
      join
      n = 0;
      while (write_valid !== 1'b1 && n < 4) begin
        @(posedge mclk);
        #1 n++;
      end
      check({31'h0, write_valid}, {31'h0, ev});
      if (ev) check({13'h0, write_word}, {13'h0, es[2:0], d});
      if (write_valid !== ev) print_verdict;
      $display("test %0d", i);
    end
    print_verdict;
  end
endmodule
